/* File: verilog/dds_map.svh */
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH
// pin widths
`define DDS_ROW_W 13
`define DDS_BA_W 2
`define DDS_DQ_W 16
`define DDS_COL_W 9
// address bit that selects all banks or auto close
`define DDS_PRE_ALL_BIT 10
// bank select bit choosing the extended mode word
`define DDS_BA_EXT_BIT 0
// mode word fields
`define DDS_MR_BL_LSB 0
`define DDS_MR_BT_BIT 3
`define DDS_MR_CL_LSB 4
`define DDS_MODE_RST 13'h0021
// burst length codes and beats
`define DDS_BL4_CODE 3'h2
`define DDS_BL8_CODE 3'h3
`define DDS_BL2_BEATS 4'h2
`define DDS_BL4_BEATS 4'h4
`define DDS_BL8_BEATS 4'h8
// read latency codes and clock edges (half clocks)
`define DDS_CL2_CODE 3'h2
`define DDS_CL25_CODE 3'h6
`define DDS_CL2_EDGES 4'h4
`define DDS_CL25_EDGES 4'h5
`define DDS_CL3_EDGES 4'h6
// command codes on {row, column, write} strobes
`define DDS_OP_ACT 3'h3
`define DDS_OP_READ 3'h5
`define DDS_OP_WRITE 3'h4
`define DDS_OP_PRE 3'h2
`define DDS_OP_REFRESH 3'h1
`define DDS_OP_LOAD 3'h0
// refresh timing
`define DDS_REF_WINDOW_MS 64
`define DDS_REF_OPS 8192
`define DDS_CORE_MHZ 125
`define DDS_TREFI_NS (`DDS_REF_WINDOW_MS * 1000000 / `DDS_REF_OPS)
`define DDS_TREFI_CYC (`DDS_TREFI_NS * `DDS_CORE_MHZ / 1000)
`endif

/* File: verilog/dds_pkg.sv */
package dds_pkg;
  typedef enum logic [2:0] {cmd_nop, cmd_act, cmd_read, cmd_write, cmd_pre, cmd_refresh, cmd_load} dds_cmd_e;
  typedef enum logic [1:0] {pwr_run, pwr_ppd, pwr_apd, pwr_sref} dds_pwr_e;
endpackage

/* File: verilog/dds_sync.sv */
module dds_sync
  import dds_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dds_sync_s;
  dds_sync_s s;
  dds_sync_s next_s;

  // first stage feeds only the second stage
  always_comb
  begin
    next_s.s1 = din;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign dout = s.s2;
endmodule // dds_sync

/* File: verilog/dds_buf.sv */
module dds_buf
  import dds_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] data;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } dds_buf_s;
  dds_buf_s s;
  dds_buf_s next_s;
  logic push;
  logic pop;

  // honest flags: ready drops when full, so the source stalls
  assign in_ready = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data = s.data[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // flush drops stale words when a new burst replaces the old one
  always_comb
  begin
    next_s = s;
    if (flush)
    begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        next_s.data[s.wp] = in_data;
        next_s.wp = (s.wp == LAST) ? '0 : s.wp + PW'(1);
      end
      if (pop)
        next_s.rp = (s.rp == LAST) ? '0 : s.rp + PW'(1);
      next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end
endmodule // dds_buf

/* File: verilog/dds_device.sv */
`include "dds_map.svh"
// Summary of operation
// - commands and address taken on clock rise
// - write data and masks sampled both strobe edges
// - each internal access fetches two data words
// - read data edge aligned with output strobe
// - masks apply separately to each half beat
// - read latency two, two-and-half or three clocks
// - burst two, four or eight, sequential/interleaved
// - four banks each hold own open row
// - auto refresh and timed self refresh supported
// - thirteen-bit row, nine or ten-bit column
// - enable low enters power-down or self refresh
// - self refresh exit and output disable asynchronous
// - power-down and self refresh ignore other inputs
// - chip select high masks every command
// - bank select picks the addressed bank
// - precharge bit high closes all banks
// - precharge bit on access requests auto close
// - mode load writes base or extended word
// - read data timed on both clock crossings
// - masked beat byte is not stored
// - strobes and select decoded each clock rise
module dds_device
  import dds_pkg::*;
#(
  parameter int COL_W = `DDS_COL_W,
  parameter int ROW_KEEP = 3,
  parameter int COL_KEEP = 5
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] diff_clock_pair,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic [`DDS_BA_W-1:0] bank_select,
  input wire logic [`DDS_ROW_W-1:0] addr,
  input wire logic [`DDS_DQ_W-1:0] dq_in,
  output logic [`DDS_DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic lower_byte_strobe_in,
  output logic lower_byte_strobe_out,
  output logic lower_byte_strobe_oe,
  input wire logic upper_byte_strobe_in,
  output logic upper_byte_strobe_out,
  output logic upper_byte_strobe_oe,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  output logic [3:0] bank_open,
  output logic power_down,
  output logic self_refresh,
  output logic [`DDS_ROW_W-1:0] mode_word,
  output logic [`DDS_ROW_W-1:0] ext_mode_word,
  output logic [`DDS_ROW_W-1:0] refresh_row
);
  localparam int AW = 2 + ROW_KEEP + COL_KEEP;
  localparam int MEM_D = 1 << AW;
  localparam int SW = 42;
  localparam logic [9:0] TREFI_LAST = 10'(`DDS_TREFI_CYC - 1);

  typedef struct packed {
    logic ck_q;
    logic stb_q;
    dds_pwr_e pwr;
    logic pd;
    logic sr;
    logic [12:0] mode;
    logic [12:0] emode;
    logic [3:0] open;
    logic [3:0][12:0] row;
    logic [12:0] ref_row;
    logic [9:0] ref_tmr;
    logic [3:0] rd_left;
    logic [2:0] rd_pair;
    logic [1:0] rd_bank;
    logic [COL_W-1:0] rd_col;
    logic rd_ap;
    logic [3:0] lat;
    logic out_on;
    logic out_half;
    logic [3:0] out_left;
    logic wr_on;
    logic [3:0] wr_left;
    logic [2:0] wr_pair;
    logic [1:0] wr_bank;
    logic [COL_W-1:0] wr_col;
    logic wr_ap;
    logic [15:0] wr_lo;
    logic [1:0] wr_lo_msk;
    logic [15:0] dq_out;
    logic dq_oe;
    logic stb_out;
    logic stb_oe;
  } dds_state_s;
  localparam dds_state_s RST_S = '{pwr: pwr_run, mode: `DDS_MODE_RST, default: '0};

  dds_state_s s;
  dds_state_s next_s;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins;
  logic [1:0] ck_s;
  logic cke_s, cs_n_s, ras_s, cas_s, we_s, lstb_s, ustb_s, lmsk_s, umsk_s;
  logic [1:0] ba_s;
  logic [12:0] addr_s;
  logic [15:0] dq_s;
  logic ck_lvl, ck_rise, ck_fall, ck_edge, stb_lvl, stb_rise, stb_fall, precharge_all_bit;
  dds_cmd_e cmd;
  logic [3:0] bl;
  logic [3:0] cl_edges;
  logic ilv;
  logic [1:0][7:0] mem [MEM_D];
  logic mem_we;
  logic [AW-1:0] wa0, wa1, ra0, ra1;
  logic [1:0] be0, be1;
  logic buf_flush, buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [31:0] buf_out_data;

  // burst column walk: wraps inside the burst block, seq adds, interleave xors
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] c, input logic [3:0] i,
                                               input logic [3:0] len, input logic il);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] lo;
    m = COL_W'(len - 4'h1);
    lo = il ? (c ^ COL_W'(i)) : (c + COL_W'(i));
    return (c & ~m) | (lo & m);
  endfunction

  // storage is a small window of the array; upper row and column bits alias
  function automatic logic [AW-1:0] idx(input logic [1:0] b, input logic [12:0] r, input logic [COL_W-1:0] c);
    return {b, r[ROW_KEEP-1:0], c[COL_KEEP-1:0]};
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'h1};
  end
  assign rst_n = rst_pipe[1];

  // every pin passes two flops; equal delay keeps data lined up with strobes
  assign pins_raw = {diff_clock_pair, cke, cs_n, row_strobe_n, col_strobe_n, write_enable_n, bank_select,
                     addr, dq_in, lower_byte_strobe_in, upper_byte_strobe_in, lower_byte_mask, upper_byte_mask};
  dds_sync #(.WIDTH(SW)) u_sync (.core_clk(core_clk), .rst_n(rst_n), .din(pins_raw), .dout(pins));
  assign {ck_s, cke_s, cs_n_s, ras_s, cas_s, we_s, ba_s, addr_s, dq_s, lstb_s, ustb_s, lmsk_s, umsk_s} = pins;

  // clock crossings of the pair: true high with complement low
  assign ck_lvl = ck_s[1] & ~ck_s[0];
  assign ck_rise = ck_lvl & ~s.ck_q;
  assign ck_fall = ~ck_lvl & s.ck_q;
  assign ck_edge = ck_rise | ck_fall;
  assign precharge_all_bit = addr_s[`DDS_PRE_ALL_BIT];
  // either lane strobe high counts as high; receivers are off outside run state
  // receivers gated off
  assign stb_lvl = lstb_s | ustb_s;
  assign stb_rise = stb_lvl & ~s.stb_q & s.wr_on & (s.pwr == pwr_run);
  assign stb_fall = ~stb_lvl & s.stb_q & s.wr_on & (s.pwr == pwr_run);

  always_comb
  begin
    cmd = cmd_nop;
    if (!cs_n_s)
      case ({ras_s, cas_s, we_s})
        `DDS_OP_ACT: cmd = cmd_act;
        `DDS_OP_READ: cmd = cmd_read;
        `DDS_OP_WRITE: cmd = cmd_write;
        `DDS_OP_PRE: cmd = cmd_pre;
        `DDS_OP_REFRESH: cmd = cmd_refresh;
        `DDS_OP_LOAD: cmd = cmd_load;
        default: cmd = cmd_nop;
      endcase
  end

  always_comb
  begin
    case (s.mode[`DDS_MR_BL_LSB +: 3])
      `DDS_BL4_CODE: bl = `DDS_BL4_BEATS;
      `DDS_BL8_CODE: bl = `DDS_BL8_BEATS;
      default: bl = `DDS_BL2_BEATS;
    endcase
    case (s.mode[`DDS_MR_CL_LSB +: 3])
      `DDS_CL2_CODE: cl_edges = `DDS_CL2_EDGES;
      `DDS_CL25_CODE: cl_edges = `DDS_CL25_EDGES;
      default: cl_edges = `DDS_CL3_EDGES;
    endcase
    ilv = s.mode[`DDS_MR_BT_BIT];
  end

  assign ra0 = idx(s.rd_bank, s.row[s.rd_bank], col_at(s.rd_col, {s.rd_pair, 1'h0}, bl, ilv));
  assign ra1 = idx(s.rd_bank, s.row[s.rd_bank], col_at(s.rd_col, {s.rd_pair, 1'h1}, bl, ilv));
  assign wa0 = idx(s.wr_bank, s.row[s.wr_bank], col_at(s.wr_col, {s.wr_pair, 1'h0}, bl, ilv));
  assign wa1 = idx(s.wr_bank, s.row[s.wr_bank], col_at(s.wr_col, {s.wr_pair, 1'h1}, bl, ilv));
  assign buf_in_valid = (s.rd_left != 4'h0);
  assign be0 = ~s.wr_lo_msk;
  assign be1 = ~{umsk_s, lmsk_s};

  always_ff @(posedge core_clk)
  begin
    if (mem_we)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (be0[k])
          mem[wa0][k] <= s.wr_lo[k*8 +: 8];
        if (be1[k])
          mem[wa1][k] <= dq_s[k*8 +: 8];
      end
    end
  end

  // two-entry buffer between the fetch stage and the edge-paced output
  dds_buf #(.WIDTH(32), .DEPTH(2)) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .flush(buf_flush),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({mem[ra1], mem[ra0]}),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // main next-state logic; later blocks win, so commands override bursts
  always_comb
  begin
    next_s = s;
    mem_we = 1'h0;
    buf_flush = 1'h0;
    buf_out_ready = 1'h0;
    next_s.ck_q = ck_lvl;
    next_s.stb_q = stb_lvl;
    if (ck_edge)
    begin
      if (s.lat != 4'h0)
        next_s.lat = s.lat - 4'h1;
      if (s.lat == 4'h2)
      begin
        next_s.stb_oe = 1'h1;
        next_s.stb_out = 1'h0;
      end
      if ((s.lat == 4'h1 || s.out_on) && s.out_left != 4'h0 && buf_out_valid)
      begin
        next_s.out_on = 1'h1;
        next_s.dq_out = s.out_half ? buf_out_data[31:16] : buf_out_data[15:0];
        next_s.dq_oe = 1'h1;
        next_s.stb_oe = 1'h1;
        next_s.stb_out = ~s.out_half;
        next_s.out_half = ~s.out_half;
        buf_out_ready = s.out_half;
        next_s.out_left = s.out_left - 4'h1;
      end
      else if (s.out_on)
      begin
        next_s.out_on = 1'h0;
        next_s.dq_oe = 1'h0;
        next_s.stb_oe = 1'h0;
      end
    end
    if (buf_in_valid && buf_in_ready)
    begin
      next_s.rd_pair = s.rd_pair + 3'h1;
      next_s.rd_left = s.rd_left - 4'h2;
      if (s.rd_left == 4'h2 && s.rd_ap)
        next_s.open[s.rd_bank] = 1'h0;
    end
    if (stb_rise)
    begin
      next_s.wr_lo = dq_s;
      next_s.wr_lo_msk = {umsk_s, lmsk_s};
    end
    if (stb_fall)
    begin
      mem_we = 1'h1;
      next_s.wr_pair = s.wr_pair + 3'h1;
      next_s.wr_left = s.wr_left - 4'h2;
      if (s.wr_left == 4'h2)
      begin
        next_s.wr_on = 1'h0;
        if (s.wr_ap)
          next_s.open[s.wr_bank] = 1'h0;
      end
    end
    if (ck_rise && s.pwr != pwr_sref)
    begin
      case (s.pwr)
        pwr_run:
        begin
          if (!cke_s)
          begin
            next_s.ref_tmr = 10'h0;
            if (cmd == cmd_refresh && s.open == 4'h0)
              next_s.pwr = pwr_sref;
            else
              next_s.pwr = (s.open == 4'h0) ? pwr_ppd : pwr_apd;
          end
          else
          begin
            case (cmd)
              cmd_act:
              begin
                next_s.open[ba_s] = 1'h1;
                next_s.row[ba_s] = addr_s;
              end
              cmd_read:
              begin
                buf_flush = 1'h1;
                next_s.rd_left = bl;
                next_s.rd_pair = 3'h0;
                next_s.rd_bank = ba_s;
                next_s.rd_col = addr_s[COL_W-1:0];
                next_s.rd_ap = precharge_all_bit;
                next_s.lat = cl_edges;
                next_s.out_left = bl;
                next_s.out_on = 1'h0;
                next_s.out_half = 1'h0;
                next_s.dq_oe = 1'h0;
                next_s.stb_oe = 1'h0;
              end
              cmd_write:
              begin
                next_s.wr_on = 1'h1;
                next_s.wr_left = bl;
                next_s.wr_pair = 3'h0;
                next_s.wr_bank = ba_s;
                next_s.wr_col = addr_s[COL_W-1:0];
                next_s.wr_ap = precharge_all_bit;
              end
              cmd_pre:
              begin
                if (precharge_all_bit)
                  next_s.open = 4'h0;
                else
                  next_s.open[ba_s] = 1'h0;
              end
              cmd_refresh:
              begin
                if (s.open == 4'h0)
                  next_s.ref_row = s.ref_row + 13'h1;
              end
              cmd_load:
              begin
                if (ba_s[`DDS_BA_EXT_BIT])
                  next_s.emode = addr_s;
                else
                  next_s.mode = addr_s;
              end
              default:
              begin
              end
            endcase
          end
        end
        default:
        begin
          if (cke_s)
            next_s.pwr = pwr_run;
        end
      endcase
    end
    if (s.pwr == pwr_sref)
    begin
      next_s.ref_tmr = (s.ref_tmr == TREFI_LAST) ? 10'h0 : s.ref_tmr + 10'h1;
      if (s.ref_tmr == TREFI_LAST)
        next_s.ref_row = s.ref_row + 13'h1;
      if (cke_s)
        next_s.pwr = pwr_run;
    end
    if (!cke_s)
    begin
      next_s.dq_oe = 1'h0;
      next_s.stb_oe = 1'h0;
    end
    next_s.pd = (next_s.pwr == pwr_ppd) || (next_s.pwr == pwr_apd);
    next_s.sr = (next_s.pwr == pwr_sref);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= RST_S;
    else
      s <= next_s;
  end

  // all outputs straight from state flops
  assign dq_out = s.dq_out;
  assign dq_oe = s.dq_oe;
  assign lower_byte_strobe_out = s.stb_out;
  assign lower_byte_strobe_oe = s.stb_oe;
  assign upper_byte_strobe_out = s.stb_out;
  assign upper_byte_strobe_oe = s.stb_oe;
  assign bank_open = s.open;
  assign power_down = s.pd;
  assign self_refresh = s.sr;
  assign mode_word = s.mode;
  assign ext_mode_word = s.emode;
  assign refresh_row = s.ref_row;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_mode_on_rise: assert property ($changed(s.mode) |-> $past(ck_rise))
    else $error("mode word changed without a clock rise");
  a_select_masks: assert property (ck_rise && cs_n_s |=> $stable(s.mode) && $stable(s.emode) && $stable(s.row))
    else $error("command taken while chip select high");
  a_pre_all_bank: assert property (ck_rise && s.pwr == pwr_run && cke_s && cmd == cmd_pre && precharge_all_bit
                                   |=> s.open == 4'h0)
    else $error("precharge all left a bank open");
  a_act_bank_row: assert property (ck_rise && s.pwr == pwr_run && cke_s && cmd == cmd_act
                                   |=> s.open[$past(ba_s)] && s.row[$past(ba_s)] == $past(addr_s))
    else $error("activate did not open the selected bank");
  a_sref_exit: assert property (s.pwr == pwr_sref && cke_s |=> s.pwr == pwr_run && !s.sr)
    else $error("self refresh did not exit on enable high");
  a_active_pd: assert property (ck_rise && s.pwr == pwr_run && !cke_s && s.open != 4'h0
                                |=> s.pwr == pwr_apd && s.pd)
    else $error("active power-down not entered");
  a_mask_keep: assert property (stb_fall && (&s.wr_lo_msk) |=> mem[$past(wa0)] == $past(mem[wa0]))
    else $error("masked beat was stored");
  a_read_edge: assert property (s.dq_oe && $changed(s.dq_out) |-> $past(ck_edge))
    else $error("read data moved off a clock crossing");
  a_first_beat: assert property (ck_edge && s.lat == 4'h1 && s.out_left != 4'h0 && buf_out_valid && cke_s
                                 |=> s.dq_oe && s.stb_out && s.stb_oe)
    else $error("first read beat missing at latency");
  a_mode_load: assert property (ck_rise && s.pwr == pwr_run && cke_s && cmd == cmd_load && !ba_s[0]
                                |=> s.mode == $past(addr_s))
    else $error("base mode word not loaded");

  c_read_burst: cover property (ck_edge && s.out_on && s.out_left == 4'h1);
  c_write_burst: cover property (stb_fall && s.wr_left == 4'h2);
  c_sref_cycle: cover property (s.pwr == pwr_sref ##1 s.pwr == pwr_run);
endmodule // dds_device

/* File: tb/dds_ctl_model.sv */
module dds_ctl_model
  import dds_pkg::*;
(
  input wire logic core_clk,
  output logic [1:0] diff_clock_pair,
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd_n,
  output logic [1:0] bank_select,
  output logic [12:0] addr,
  output logic [15:0] dq,
  output logic dqs,
  output logic [1:0] mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;

  // idle pins at time zero, deselected
  initial
  begin
    cnt = 4'h0;
    diff_clock_pair = 2'b01;
    cke = 1'b1;
    cs_n = 1'b1;
    cmd_n = 3'h7;
    bank_select = 2'h0;
    addr = 13'h0000;
    dq = 16'h0000;
    dqs = 1'b0;
    mask = 2'h0;
  end

  // link clock, ten core cycles a period; runs free as a real pair does
  always @(posedge core_clk)
  begin
    cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
    if (cnt == 4'h4)
      diff_clock_pair <= 2'b10;
    else if (cnt == 4'h9)
      diff_clock_pair <= 2'b01;
  end

  // held from fall to fall around one rise
  task automatic cmd(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a, input logic sel_n);
    @(posedge core_clk iff cnt == 4'h9);
    cs_n <= sel_n;
    cmd_n <= op;
    bank_select <= ba;
    addr <= a;
    @(posedge core_clk iff cnt == 4'h9);
    // released lines show the inverse so stale values never look valid
    cs_n <= 1'b1;
    cmd_n <= ~op;
    bank_select <= ~ba;
    addr <= ~a;
  endtask

  // enable only moves on a link fall, never inside an access
  task automatic hold_cke(input logic v);
    @(posedge core_clk iff cnt == 4'h9);
    cke <= v;
  endtask

  // strobe edge centred, data stable four cycles each side
  task automatic wr(input logic [15:0] w0, input logic [15:0] w1, input logic [1:0] m0, input logic [1:0] m1);
    // one edge first, so back-to-back pairs never drive the data lines twice in one step
    @(posedge core_clk);
    dq <= w0;
    mask <= m0;
    repeat (4) @(posedge core_clk);
    dqs <= 1'b1;
    repeat (4) @(posedge core_clk);
    dq <= w1;
    mask <= m1;
    repeat (4) @(posedge core_clk);
    dqs <= 1'b0;
    repeat (4) @(posedge core_clk);
    dq <= ~w1;
    mask <= ~m1;
  endtask
endmodule // dds_ctl_model

/* File: tb/tb_ddr_sdram_command_interface.sv */
`include "dds_map.svh"
module tb_ddr_sdram_command_interface
  import dds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] ck;
  logic cke, cs_n, dqs_c, dq_oe, ls_out, ls_oe, us_out, us_oe, power_down, self_refresh;
  logic [2:0] cmd_n;
  logic [1:0] ba, mask;
  logic [12:0] addr, mode_word, ext_mode_word, refresh_row;
  logic [15:0] dq_c, dq_out;
  logic [3:0] bank_open;
  wire logic [15:0] dq_w = dq_oe ? dq_out : dq_c;
  wire logic dqs_w = ls_oe ? ls_out : dqs_c;
  int n_mismatch = 0;
  int tests_run = 0;

  always #4 core_clk = ~core_clk;

  dds_ctl_model u_ctl (.core_clk(core_clk), .diff_clock_pair(ck), .cke(cke), .cs_n(cs_n), .cmd_n(cmd_n),
    .bank_select(ba), .addr(addr), .dq(dq_c), .dqs(dqs_c), .mask(mask));

  dds_device DUT (.core_clk(core_clk), .rstn(rstn), .diff_clock_pair(ck), .cke(cke), .cs_n(cs_n),
    .row_strobe_n(cmd_n[2]), .col_strobe_n(cmd_n[1]), .write_enable_n(cmd_n[0]), .bank_select(ba),
    .addr(addr), .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .lower_byte_strobe_in(dqs_w),
    .lower_byte_strobe_out(ls_out), .lower_byte_strobe_oe(ls_oe), .upper_byte_strobe_in(dqs_w),
    .upper_byte_strobe_out(us_out), .upper_byte_strobe_oe(us_oe), .lower_byte_mask(mask[0]),
    .upper_byte_mask(mask[1]), .bank_open(bank_open), .power_down(power_down), .self_refresh(self_refresh),
    .mode_word(mode_word), .ext_mode_word(ext_mode_word), .refresh_row(refresh_row));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // wait for the strobe level of a beat, bounded, then take the beat
  task automatic rd_beat(input logic lvl, input logic [15:0] exp);
    int i;
    i = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      i++;
    end while (!(ls_oe === 1'b1 && ls_out === lvl) && i < 80);
    chk("read beat", dq_out, exp);
    chk("drive enables", {11'h0, dq_oe, us_oe, ls_oe, us_out, ls_out}, {11'h0, 3'h7, lvl, lvl});
  endtask

  task automatic t_reset();
    chk("mode word", {3'h0, mode_word}, 16'h0021);
    chk("banks", {12'h0, bank_open}, 16'h0);
    chk("low power", {14'h0, power_down, self_refresh}, 16'h0);
  endtask

  task automatic t_mode();
    u_ctl.cmd(`DDS_OP_LOAD, 2'h1, 13'h0005, 1'b0);
    u_ctl.cmd(`DDS_OP_LOAD, 2'h0, 13'h0029, 1'b0);
    u_ctl.cmd(`DDS_OP_LOAD, 2'h0, 13'h0031, 1'b1);
    chk("ext mode", {3'h0, ext_mode_word}, 16'h0005);
    chk("mode after deselect", {3'h0, mode_word}, 16'h0029);
  endtask

  task automatic t_bank();
    u_ctl.cmd(`DDS_OP_ACT, 2'h2, 13'h0005, 1'b0);
    u_ctl.cmd(`DDS_OP_ACT, 2'h0, 13'h0005, 1'b0);
    u_ctl.cmd(`DDS_OP_ACT, 2'h1, 13'h0005, 1'b1);
    chk("banks open", {12'h0, bank_open}, 16'h5);
    u_ctl.cmd(`DDS_OP_PRE, 2'h0, 13'h0000, 1'b0);
    u_ctl.cmd(`DDS_OP_REFRESH, 2'h0, 13'h0000, 1'b0);
    chk("single close", {12'h0, bank_open}, 16'h4);
    chk("refresh refused", {3'h0, refresh_row}, 16'h0);
  endtask

  task automatic t_data();
    u_ctl.cmd(`DDS_OP_WRITE, 2'h2, 13'h0004, 1'b0);
    u_ctl.wr(16'h1234, 16'h5678, 2'h0, 2'h0);
    u_ctl.cmd(`DDS_OP_WRITE, 2'h2, 13'h0404, 1'b0);
    u_ctl.wr(16'haaaa, 16'hbbbb, 2'h1, 2'h2);
    repeat (20) @(posedge core_clk);
    chk("auto close", {12'h0, bank_open}, 16'h0);
    u_ctl.cmd(`DDS_OP_ACT, 2'h2, 13'h0005, 1'b0);
    u_ctl.cmd(`DDS_OP_READ, 2'h2, 13'h0004, 1'b0);
    rd_beat(1'b1, 16'haa34);
    rd_beat(1'b0, 16'h56bb);
    repeat (30) @(posedge core_clk);
  endtask

  task automatic t_power();
    u_ctl.hold_cke(1'b0);
    repeat (30) @(posedge core_clk);
    chk("active power-down", {15'h0, power_down}, 16'h1);
    u_ctl.cmd(`DDS_OP_PRE, 2'h0, 13'h0400, 1'b0);
    u_ctl.hold_cke(1'b1);
    repeat (30) @(posedge core_clk);
    chk("power-down exit", {15'h0, power_down}, 16'h0);
    chk("inputs ignored", {12'h0, bank_open}, 16'h4);
    u_ctl.cmd(`DDS_OP_PRE, 2'h0, 13'h0400, 1'b0);
    u_ctl.cmd(`DDS_OP_REFRESH, 2'h0, 13'h0000, 1'b0);
    chk("all closed", {12'h0, bank_open}, 16'h0);
    chk("refresh row", {3'h0, refresh_row}, 16'h1);
  endtask

  // burst of four, sequential order, three-clock latency; first beat fully masked keeps old word
  task automatic t_burst();
    u_ctl.cmd(`DDS_OP_LOAD, 2'h0, 13'h0032, 1'b0);
    u_ctl.cmd(`DDS_OP_ACT, 2'h2, 13'h0005, 1'b0);
    u_ctl.cmd(`DDS_OP_WRITE, 2'h2, 13'h0004, 1'b0);
    u_ctl.wr(16'h1111, 16'h2222, 2'h3, 2'h0);
    u_ctl.wr(16'h3333, 16'h4444, 2'h0, 2'h0);
    u_ctl.cmd(`DDS_OP_READ, 2'h2, 13'h0406, 1'b0);
    rd_beat(1'b1, 16'h3333);
    rd_beat(1'b0, 16'h4444);
    rd_beat(1'b1, 16'haa34);
    rd_beat(1'b0, 16'h2222);
    repeat (20) @(posedge core_clk);
    chk("read auto close", {12'h0, bank_open}, 16'h0);
  endtask

  // idle power-down, then self refresh entered by refresh with enable low
  task automatic t_sref();
    u_ctl.hold_cke(1'b0);
    repeat (30) @(posedge core_clk);
    chk("precharge power-down", {14'h0, power_down, self_refresh}, 16'h2);
    u_ctl.hold_cke(1'b1);
    repeat (30) @(posedge core_clk);
    fork
      u_ctl.hold_cke(1'b0);
      u_ctl.cmd(`DDS_OP_REFRESH, 2'h0, 13'h0000, 1'b0);
    join
    chk("self refresh entry", {14'h0, power_down, self_refresh}, 16'h1);
    repeat (1000) @(posedge core_clk);
    chk("self refresh row", {3'h0, refresh_row}, 16'h2);
    u_ctl.hold_cke(1'b1);
    // exit must come before the next link rise reaches the device
    repeat (4) @(posedge core_clk);
    chk("self refresh exit", {14'h0, power_down, self_refresh}, 16'h0);
  endtask

  // watchdog: the sequence needs under 30 us
  initial
  begin
    #100us;
    n_mismatch++;
    test_done();
  end

  // five cycles of reset, then let the synchronisers settle
  initial
  begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_reset();
    t_mode();
    t_bank();
    t_data();
    t_power();
    t_burst();
    t_sref();
    test_done();
  end
endmodule // tb_ddr_sdram_command_interface
